// file: hdl/scan_pkg.sv
package scan_pkg;
  // ==========================================================
  // geometry
  localparam int ROWS = 10;
  localparam int COLS = 8;
  localparam int WIDE_ROWS = 4;
  localparam logic [7:0] MASK_WIDE = 8'hFF;
  localparam logic [7:0] MASK_NARROW = 8'h7F;
  localparam logic [9:0] ROWS_IDLE = 10'h3FF;
  localparam logic [3:0] LAST_ROW = 4'h9;
  // ==========================================================
  // stack
  localparam int STACK_DEPTH = 8;
  localparam int ENT_W = 9;
  localparam int ENT_KNOB_BIT = 8;
  localparam int KNOB_DIR_BIT = 7;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ROW_TIME_NS = 80_000;
  localparam int DEBOUNCE_NS = 1_000_000;
  localparam int ROW_DWELL_CYC = ROW_TIME_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;
  typedef logic [16:0] cnt_t;
  typedef logic [3:0] sp_t;
  typedef logic [3:0] row_t;
  // ==========================================================
  // states
  typedef enum logic [10:0] {
    ST_INIT = 11'h001,
    ST_KNOB = 11'h002,
    ST_KDEB = 11'h004,
    ST_ROW = 11'h008,
    ST_RDEB = 11'h010,
    ST_PROC = 11'h020,
    ST_ENDSCAN = 11'h040,
    ST_POP = 11'h080,
    ST_LOOK = 11'h100,
    ST_LOAD = 11'h200,
    ST_WAIT = 11'h0400
  } state_t;
endpackage

// file: hdl/stack_mem.sv
`timescale 1ns/1ps
module stack_mem #(
  parameter int DEPTH = 8
) (
  input logic core_clk,
  input logic nrst,
  input logic wr_en,
  input scan_pkg::sp_t wr_addr,
  input logic [8:0] wr_data,
  input scan_pkg::sp_t rd_addr,
  output logic [8:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][8:0] mem;
    logic [8:0] rd_r;
  } mem_state_t;
  mem_state_t r, nxt;

  always_comb
  begin
    nxt = r;
    if (wr_en && (32'(wr_addr) < DEPTH))
    begin
      nxt.mem[wr_addr] = wr_data;
    end
    nxt.rd_r = (32'(rd_addr) < DEPTH) ? r.mem[rd_addr] : 9'h000;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= nxt;
  end

  assign rd_data = r.rd_r;
endmodule

// file: hdl/keycode_rom.sv
`timescale 1ns/1ps
module keycode_rom (
  input logic core_clk,
  input logic nrst,
  input logic [6:0] key_addr,
  output logic [7:0] key_code
);
  typedef struct packed {
    logic [7:0] code_r;
  } rom_state_t;
  rom_state_t r, nxt;

  // address {row,col} maps to code row*8+col
  always_comb
  begin
    nxt = r;
    nxt.code_r = {1'b0, key_addr};
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      r <= '0;
    else
      r <= nxt;
  end

  assign key_code = r.code_r;
endmodule

// file: hdl/front_panel_key_scanner.sv
`timescale 1ns/1ps
module front_panel_key_scanner #(
  parameter int DEBOUNCE_CYC = scan_pkg::DEBOUNCE_CYC,
  parameter int ROW_DWELL_CYC = scan_pkg::ROW_DWELL_CYC,
  parameter int STACK_DEPTH = scan_pkg::STACK_DEPTH
) (
  input logic core_clk,
  input logic nrst,
  input logic [7:0] col_in,
  input logic [1:0] knob_in,
  input logic host_read,
  output logic [9:0] row_drive_n,
  output logic [7:0] out_data,
  output logic key_request_n,
  output logic knob_request_n
);
  typedef struct packed {
    scan_pkg::state_t state;
    scan_pkg::row_t row;
    scan_pkg::cnt_t cnt;
    logic [9:0][7:0] keys;
    logic [1:0] knob;
    logic [1:0] knob_pre;
    logic [7:0] sample;
    logic [7:0] pend;
    scan_pkg::sp_t sp;
    logic init_scan;
    logic first_pass;
    logic [9:0] row_n;
    logic [7:0] data;
    logic key_req_n;
    logic knob_req_n;
    logic ent_knob;
    logic [7:0] ent_byte;
  } scan_state_t;

  scan_state_t r, nxt;
  logic wr_en;
  logic [8:0] wr_data;
  logic [8:0] rd_data;
  logic [7:0] rom_code;
  scan_pkg::sp_t rd_addr;

  // ==========================================================
  // helpers
  function automatic logic [7:0] col_mask(input scan_pkg::row_t row);
    col_mask = (32'(row) < scan_pkg::WIDE_ROWS) ? scan_pkg::MASK_WIDE
                                                 : scan_pkg::MASK_NARROW;
  endfunction

  function automatic logic [2:0] lowest_bit(input logic [7:0] v);
    lowest_bit = 3'h0;
    for (int i = scan_pkg::COLS - 1; i >= 0; i--)
    begin
      if (v[i])
        lowest_bit = 3'(i);
    end
  endfunction

  function automatic logic [9:0] row_drive(input scan_pkg::row_t row);
    row_drive = ~(10'h001 << row);
  endfunction

  // ==========================================================
  // storage
  assign rd_addr = r.sp - 4'h1;

  stack_mem #(
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .core_clk(core_clk),
    .nrst(nrst),
    .wr_en(wr_en),
    .wr_addr(r.sp),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  keycode_rom u_rom (
    .core_clk(core_clk),
    .nrst(nrst),
    .key_addr(rd_data[6:0]),
    .key_code(rom_code)
  );

  // ==========================================================
  // scan sequencer
  always_comb
  begin
    logic [7:0] smp;
    logic [2:0] b;
    logic room;
    logic next_row;
    smp = col_in | ~col_mask(r.row);
    b = lowest_bit(r.pend);
    room = (32'(r.sp) < STACK_DEPTH);
    next_row = 1'b0;
    nxt = r;
    wr_en = 1'b0;
    wr_data = 9'h000;
    if (r.cnt != '0)
      nxt.cnt = r.cnt - 17'h0_0001;
    case (r.state)
      scan_pkg::ST_INIT:
      begin
        nxt.keys = '1;
        nxt.knob = knob_in;
        nxt.state = scan_pkg::ST_KNOB;
      end
      scan_pkg::ST_KNOB:
      begin
        if (knob_in != r.knob)
        begin
          nxt.knob_pre = knob_in;
          nxt.cnt = scan_pkg::cnt_t'(DEBOUNCE_CYC - 1);
          nxt.state = scan_pkg::ST_KDEB;
        end
        else
        begin
          nxt.row = '0;
          nxt.row_n = row_drive('0);
          nxt.cnt = scan_pkg::cnt_t'(ROW_DWELL_CYC - 1);
          nxt.state = scan_pkg::ST_ROW;
        end
      end
      scan_pkg::ST_KDEB:
      begin
        if (r.cnt == '0)
        begin
          if (knob_in == r.knob_pre && room)
          begin
            wr_en = 1'b1;
            // equal means up, stored as one
            wr_data = {1'b1, ~(r.knob[0] ^ r.knob_pre[1]), 5'h00, r.knob_pre};
            nxt.knob = r.knob_pre;
          end
          nxt.row = '0;
          nxt.row_n = row_drive('0);
          nxt.cnt = scan_pkg::cnt_t'(ROW_DWELL_CYC - 1);
          nxt.state = scan_pkg::ST_ROW;
        end
      end
      scan_pkg::ST_ROW:
      begin
        if (r.cnt == '0)
        begin
          if ((smp ^ r.keys[r.row]) != 8'h00)
          begin
            nxt.sample = smp;
            nxt.cnt = scan_pkg::cnt_t'(DEBOUNCE_CYC - 1);
            nxt.state = scan_pkg::ST_RDEB;
          end
          else
            next_row = 1'b1;
        end
      end
      scan_pkg::ST_RDEB:
      begin
        if (r.cnt == '0)
        begin
          if (smp != r.sample)
            next_row = 1'b1;
          else if (r.first_pass)
          begin
            nxt.first_pass = 1'b0;
            nxt.row_n = scan_pkg::ROWS_IDLE;
            nxt.state = scan_pkg::ST_KNOB;
          end
          else
          begin
            nxt.pend = r.sample ^ r.keys[r.row];
            nxt.state = scan_pkg::ST_PROC;
          end
        end
      end
      scan_pkg::ST_PROC:
      begin
        if (r.pend == 8'h00)
          next_row = 1'b1;
        else
        begin
          nxt.pend[b] = 1'b0;
          if (r.sample[b])
            nxt.keys[r.row][b] = 1'b1;
          else if (room)
          begin
            wr_en = 1'b1;
            wr_data = {1'b0, 1'b0, r.row, b};
            nxt.keys[r.row][b] = 1'b0;
          end
        end
      end
      scan_pkg::ST_ENDSCAN:
      begin
        if (r.sp == '0)
          nxt.state = scan_pkg::ST_KNOB;
        else if (!r.init_scan && r.sp > 4'h1)
        begin
          nxt.sp = '0;
          nxt.state = scan_pkg::ST_KNOB;
        end
        else
          nxt.state = scan_pkg::ST_POP;
      end
      scan_pkg::ST_POP:
      begin
        nxt.sp = r.sp - 4'h1;
        nxt.state = scan_pkg::ST_LOOK;
      end
      scan_pkg::ST_LOOK:
      begin
        nxt.ent_knob = rd_data[scan_pkg::ENT_KNOB_BIT];
        nxt.ent_byte = rd_data[7:0];
        nxt.state = scan_pkg::ST_LOAD;
      end
      scan_pkg::ST_LOAD:
      begin
        nxt.data = r.ent_knob ? r.ent_byte : rom_code;
        nxt.key_req_n = r.ent_knob;
        nxt.knob_req_n = ~r.ent_knob;
        nxt.state = scan_pkg::ST_WAIT;
      end
      scan_pkg::ST_WAIT:
      begin
        nxt.knob = knob_in;
        if (host_read)
        begin
          nxt.key_req_n = 1'b1;
          nxt.knob_req_n = 1'b1;
          if (r.sp != '0)
            nxt.state = scan_pkg::ST_POP;
          else
          begin
            nxt.init_scan = 1'b0;
            nxt.first_pass = 1'b1;
            nxt.state = scan_pkg::ST_KNOB;
          end
        end
      end
      default:
        nxt.state = scan_pkg::ST_INIT;
    endcase
    if (wr_en)
      nxt.sp = r.sp + 4'h1;
    if (next_row)
    begin
      if (r.row == scan_pkg::LAST_ROW)
      begin
        nxt.row_n = scan_pkg::ROWS_IDLE;
        nxt.state = scan_pkg::ST_ENDSCAN;
      end
      else
      begin
        nxt.row = r.row + 4'h1;
        nxt.row_n = row_drive(r.row + 4'h1);
        nxt.cnt = scan_pkg::cnt_t'(ROW_DWELL_CYC - 1);
        nxt.state = scan_pkg::ST_ROW;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.state <= scan_pkg::ST_INIT;
      r.keys <= '1;
      r.init_scan <= 1'b1;
      r.row_n <= scan_pkg::ROWS_IDLE;
      r.key_req_n <= 1'b1;
      r.knob_req_n <= 1'b1;
    end
    else
      r <= nxt;
  end

  assign row_drive_n = r.row_n;
  assign out_data = r.data;
  assign key_request_n = r.key_req_n;
  assign knob_request_n = r.knob_req_n;

  // ==========================================================
  // checks
  sequence seq_enter_rdeb;
    r.state != scan_pkg::ST_RDEB ##1 r.state == scan_pkg::ST_RDEB;
  endsequence

  sequence seq_host_done;
    r.state == scan_pkg::ST_WAIT && host_read && r.sp == '0;
  endsequence

  AST_INIT_FILL: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_INIT |=> r.keys == '1 && r.state == scan_pkg::ST_KNOB)
    else $error("key state not filled open after init");

  AST_ONE_ROW: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_ROW |-> $onehot(~row_drive_n) && row_drive_n[r.row] == 1'b0)
    else $error("scanned row not the only one driven low");

  AST_DEB_LOAD: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_enter_rdeb |-> r.cnt == scan_pkg::cnt_t'(DEBOUNCE_CYC - 1))
    else $error("debounce wait not loaded to full interval");

  AST_REQ_EXCL: assert property (@(posedge core_clk) disable iff (!nrst)
    !(key_request_n == 1'b0 && knob_request_n == 1'b0))
    else $error("both request lines low");

  AST_ABORT: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_ENDSCAN && !r.init_scan && r.sp > 4'h1
    |=> r.sp == '0 && r.state == scan_pkg::ST_KNOB && key_request_n && knob_request_n)
    else $error("multiple entries not aborted");

  AST_LOAD_REQ: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_POP |-> ##3 (key_request_n ^ knob_request_n)
    && r.state == scan_pkg::ST_WAIT)
    else $error("request not lowered three cycles after pop");

  AST_RELEASE: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_WAIT && host_read |=> key_request_n && knob_request_n)
    else $error("request not raised after host read");

  AST_EMPTY_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_host_done |=> !r.init_scan && r.first_pass && r.state == scan_pkg::ST_KNOB)
    else $error("first-scan flag not cleared on empty stack");

  AST_KNOB_TRACK: assert property (@(posedge core_clk) disable iff (!nrst)
    r.state == scan_pkg::ST_WAIT |=> r.knob == $past(knob_in))
    else $error("knob not tracked while waiting");

  AST_FULL_DROP: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en |-> 32'(r.sp) < STACK_DEPTH ##1 r.sp == $past(r.sp) + 4'h1)
    else $error("push past full stack");
endmodule

// file: testbench/host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side: reads the buffer after a chosen delay per request
module host_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] out_data,
  input wire logic key_request_n,
  input wire logic knob_request_n,
  input wire logic [7:0] delay,
  output logic host_read,
  output logic got_valid,
  output logic [8:0] got
);
  initial
  begin
    host_read = 1'b0;
    got_valid = 1'b0;
    got = 9'h000;
    forever
    begin
      @(posedge core_clk);
      #1;
      if (nrst && !(key_request_n && knob_request_n))
      begin
        repeat (delay) @(posedge core_clk);
        #1;
        host_read = 1'b1;
        got = {~knob_request_n, out_data};
        got_valid = 1'b1;
        @(posedge core_clk);
        #1;
        host_read = 1'b0;
        got_valid = 1'b0;
        // no second read until the request has gone back high
        do
        begin
          @(posedge core_clk);
          #1;
        end
        while (!(key_request_n && knob_request_n));
      end
    end
  end
endmodule

// file: testbench/tb_front_panel_key_scanner.sv
`timescale 1ns/1ps
module tb_front_panel_key_scanner;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] col_in;
  logic [1:0] knob_in = 2'h0;
  logic host_read;
  logic [9:0] row_drive_n;
  logic [7:0] out_data;
  logic key_request_n;
  logic knob_request_n;
  logic [7:0] delay = 8'h00;
  logic got_valid;
  logic [8:0] got;
  logic [7:0] closed [10];
  logic [8:0] got_q [$];
  logic [31:0] seed = 32'h0001_6597;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  // ==========================================================
  // switch matrix with column pull-ups
  always_comb
  begin
    col_in = 8'hFF;
    for (int r = 0; r < 10; r++)
      if (!row_drive_n[r])
        col_in = ~closed[r] | ((r >= 4) ? 8'h80 : 8'h00);
  end

  front_panel_key_scanner #(.DEBOUNCE_CYC(20), .ROW_DWELL_CYC(4), .STACK_DEPTH(8))
  u_front_panel_key_scanner (.core_clk(core_clk), .nrst(nrst), .col_in(col_in),
    .knob_in(knob_in), .host_read(host_read), .row_drive_n(row_drive_n),
    .out_data(out_data), .key_request_n(key_request_n), .knob_request_n(knob_request_n));

  host_model u_host_model (.core_clk(core_clk), .nrst(nrst), .out_data(out_data),
    .key_request_n(key_request_n), .knob_request_n(knob_request_n), .delay(delay),
    .host_read(host_read), .got_valid(got_valid), .got(got));

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output int v, input int m);
    seed = lfsr_next(seed);
    v = int'(seed[15:0]) % m;
  endtask

  function automatic logic [8:0] key_code(input int r, input int c);
    return {2'h0, 4'(r), 3'(c)};
  endfunction

  function automatic logic [8:0] knob_byte(input logic [1:0] o, input logic [1:0] n);
    return {1'b1, ~(o[0] ^ n[1]), 5'h00, n};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic take(input logic [8:0] exp);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    check(got_q.size() ? {7'h00, got_q.pop_front()} : 16'hFFFF, {7'h00, exp});
    #1;
  endtask

  task automatic quiet(input int n);
    tick(n);
    check(16'(got_q.size()), 16'h0000);
  endtask

  task automatic wait_row(input int n);
    while (row_drive_n[n])
      @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    repeat (10) @(posedge core_clk);
    check({4'h0, row_drive_n, key_request_n, knob_request_n}, 16'h0FFF);
    check({8'h00, out_data}, 16'h0000);
    #1;
    nrst = 1'b1;
  endtask

  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, fail_count);
  endtask

  // ==========================================================
  // collector, wire monitor and hang limit
  always @(posedge core_clk)
  begin
    cycles++;
    if (got_valid)
      got_q.push_back(got);
    if (nrst)
      check(16'($countones(~row_drive_n) <= 1 && (key_request_n || knob_request_n)), 16'h0001);
    if (cycles == 60000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================
  // scenarios
  initial
  begin
    int r;
    int c;
    int d;
    logic [1:0] k;
    foreach (closed[i])
      closed[i] = 8'h00;
    for (int i = 0; i < 5; i++)
      closed[i * 2][i] = 1'b1;
    do_reset();
    for (int i = 4; i >= 0; i--)
      take(key_code(i * 2, i));
    quiet(400);
    foreach (closed[i])
      closed[i] = 8'h00;
    quiet(600);
    done("power-up");
    wait_row(0);
    closed[1][3] = 1'b1;
    closed[7][5] = 1'b1;
    quiet(800);
    closed[1][3] = 1'b0;
    closed[7][5] = 1'b0;
    quiet(800);
    rnd(r, 10);
    rnd(c, 7);
    wait_row(r);
    closed[r][c] = 1'b1;
    tick(6);
    closed[r][c] = 1'b0;
    quiet(600);
    done("abort and bounce");
    repeat (6)
    begin
      rnd(r, 10);
      rnd(c, r < 4 ? 8 : 7);
      rnd(d, 40);
      delay = 8'(d);
      closed[r][c] = 1'b1;
      take(key_code(r, c));
      closed[r][c] = 1'b0;
      quiet(300);
    end
    done("single keys");
    delay = 8'h03;
    for (int i = 0; i < 8; i++)
    begin
      k = knob_in;
      knob_in = (i < 4) ? {k[0], ~k[1]} : {~k[0], k[1]};
      take(knob_byte(k, knob_in));
    end
    k = knob_in;
    knob_in = {k[0], ~k[1]};
    tick(3);
    knob_in = k;
    quiet(400);
    delay = 8'h28;
    closed[2][6] = 1'b1;
    wait (!key_request_n);
    #1;
    knob_in = {k[0], ~k[1]};
    take(key_code(2, 6));
    closed[2][6] = 1'b0;
    quiet(400);
    done("knob");
    for (int i = 0; i < 9; i++)
      closed[i][(i * 3) % 7] = 1'b1;
    do_reset();
    for (int i = 7; i >= 0; i--)
      take(key_code(i, (i * 3) % 7));
    take(key_code(8, 3));
    quiet(300);
    done("full stack");
    conclude();
  end
endmodule
